// File: hw/sdmcfg_consts.vh
// Register map, field positions, reset values and command codes of the SDRAM configuration block
`ifndef SDMCFG_CONSTS_VH
`define SDMCFG_CONSTS_VH

// ****************************************
// Register indices and byte addresses
// ****************************************
`define SDMCFG_IDX_MEMORY_CONTROL   12'h06A
`define SDMCFG_IDX_BANK_GEOMETRY    12'h06C
`define SDMCFG_IDX_REFRESH_TIMING   12'h068
`define SDMCFG_ADDR_MEMORY_CONTROL  12'h1A8
`define SDMCFG_ADDR_BANK_GEOMETRY   12'h1B0
`define SDMCFG_ADDR_REFRESH_TIMING  12'h1A0

// ****************************************
// Reset values
// ****************************************
`define SDMCFG_RST_MEMORY_CONTROL   16'h0004
`define SDMCFG_RST_BANK_GEOMETRY    16'h0331
`define SDMCFG_RST_REFRESH_TIMING   16'h0003

// ****************************************
// Field positions and writable masks
// ****************************************
`define SDMCFG_CTL_SELF_REFRESH_BIT 0
`define SDMCFG_CTL_CAS_LO           1
`define SDMCFG_CTL_CAS_HI           2
`define SDMCFG_CTL_MODE_TRIG_BIT    3
`define SDMCFG_CTL_WR_MASK          16'h000F
`define SDMCFG_BANK_WR_MASK         16'h3FFF
`define SDMCFG_TIM_WR_MASK          16'h0007
`define SDMCFG_BANK_CS1_MASK_BIT    13
`define SDMCFG_BANK_WIDTH_BIT       12
`define SDMCFG_BANK_SIZE_LO         8
`define SDMCFG_BANK_SIZE_HI         11
`define SDMCFG_BANK_ROW_LO          5
`define SDMCFG_BANK_ROW_HI          7
`define SDMCFG_BANK_BANKS_LO        3
`define SDMCFG_BANK_BANKS_HI        4
`define SDMCFG_BANK_COL_LO          0
`define SDMCFG_BANK_COL_HI          2

// ****************************************
// Latency codes and SDRAM commands {ras_n, cas_n, we_n}
// ****************************************
`define SDMCFG_CAS_CODE_2CLK        2'h2
`define SDMCFG_CAS_LAT_2            3'h2
`define SDMCFG_CAS_LAT_3            3'h3
`define SDMCFG_CMD_NOP              3'h7
`define SDMCFG_CMD_MODE_LOAD        3'h0
`define SDMCFG_CMD_SELF_REFRESH     3'h1

`endif

// File: hw/sdmcfg_top.v
// SDRAM mode, self-refresh and geometry configuration with APB register access
`timescale 1ns/1ps
`include "sdmcfg_consts.vh"

module sdmcfg_top
(
  input  wire        pclk,              // System clock, 20 MHz
  input  wire        presetn,           // Asynchronous reset, active low
  input  wire        psel,              // APB select
  input  wire        penable,           // APB access phase
  input  wire        pwrite,            // APB write direction
  input  wire [11:0] paddr,             // APB byte address
  input  wire [31:0] pwdata,            // APB write data
  output reg  [31:0] prdata,            // APB read data
  output wire        pready,            // APB ready, never waits
  output wire        pslverr,           // APB error on unmapped address
  input  wire        banks_idle,        // All banks precharged, no access running
  output reg         sdram_cke,         // SDRAM clock enable
  output reg  [1:0]  sdram_cs_n,        // SDRAM chip selects, active low
  output reg         sdram_ras_n,       // SDRAM row strobe, active low
  output reg         sdram_cas_n,       // SDRAM column strobe, active low
  output reg         sdram_we_n,        // SDRAM write enable, active low
  output reg  [12:0] sdram_addr,        // SDRAM address, carries mode word
  output wire        ctrl_ready,        // Sequencer idle, accesses allowed
  output wire [2:0]  cas_latency,       // Read latency in clocks
  output wire [3:0]  row_addr_bits,     // Row address width
  output wire [3:0]  col_addr_bits,     // Column address width
  output wire [3:0]  bank_count,        // Number of internal banks
  output wire [3:0]  sdram_size_code,   // Size code as programmed
  output wire        data_width_type,   // Data bus width type as programmed
  output wire        cs1_masked,        // Second chip select masked
  output wire        geometry_reserved  // A reserved row or column code is set
);

  // ****************************************
  // States
  // ****************************************
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_MODE = 2'h1;
  localparam [1:0] ST_SREF = 2'h2;
  localparam [1:0] ST_SREX = 2'h3;

  reg  [15:0] memory_control_reg;
  reg  [15:0] memory_bank_geometry_reg;
  reg  [15:0] refresh_timing_reg;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [2:0]  exit_count_reg;

  wire        wr_en;
  wire        rd_setup;
  wire        mapped;
  wire        mode_issue;
  wire        trig_write_one;
  wire        self_refresh_enable;
  wire [1:0]  column_latency_select;
  wire [2:0]  self_refresh_exit_delay;
  wire [2:0]  row_width_select;
  wire [1:0]  bank_count_select;
  wire [2:0]  column_width_select;
  wire [2:0]  exit_clocks;

  // ****************************************
  // Functions
  // ****************************************
  // Reserved latency codes fall back to three clocks
  function [2:0] cas_clocks;
    input [1:0] code;
    begin
      if (code == `SDMCFG_CAS_CODE_2CLK)
        cas_clocks = `SDMCFG_CAS_LAT_2;
      else
        cas_clocks = `SDMCFG_CAS_LAT_3;
    end
  endfunction

  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `SDMCFG_ADDR_MEMORY_CONTROL) || (a == `SDMCFG_ADDR_BANK_GEOMETRY) ||
                  (a == `SDMCFG_ADDR_REFRESH_TIMING);
    end
  endfunction

  // ****************************************
  // APB slave
  // ****************************************
  assign pready   = 1'b1;
  assign mapped   = is_mapped(paddr);
  assign pslverr  = psel & penable & ~mapped;
  assign wr_en    = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_setup)
    begin
      case (paddr)
        `SDMCFG_ADDR_MEMORY_CONTROL: prdata <= {16'h0000, memory_control_reg};
        `SDMCFG_ADDR_BANK_GEOMETRY:  prdata <= {16'h0000, memory_bank_geometry_reg};
        `SDMCFG_ADDR_REFRESH_TIMING: prdata <= {16'h0000, refresh_timing_reg};
        default:                     prdata <= 32'h00000000;
      endcase
    end
  end

  assign trig_write_one = wr_en && (paddr == `SDMCFG_ADDR_MEMORY_CONTROL) && pwdata[`SDMCFG_CTL_MODE_TRIG_BIT];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      memory_control_reg       <= `SDMCFG_RST_MEMORY_CONTROL;
      memory_bank_geometry_reg <= `SDMCFG_RST_BANK_GEOMETRY;
      refresh_timing_reg       <= `SDMCFG_RST_REFRESH_TIMING;
    end
    else
    begin
      if (wr_en && (paddr == `SDMCFG_ADDR_MEMORY_CONTROL))
        memory_control_reg <= pwdata[15:0] & `SDMCFG_CTL_WR_MASK;
      else if (mode_issue)
        memory_control_reg[`SDMCFG_CTL_MODE_TRIG_BIT] <= 1'b0;
      if (wr_en && (paddr == `SDMCFG_ADDR_BANK_GEOMETRY))
        memory_bank_geometry_reg <= pwdata[15:0] & `SDMCFG_BANK_WR_MASK;
      if (wr_en && (paddr == `SDMCFG_ADDR_REFRESH_TIMING))
        refresh_timing_reg <= pwdata[15:0] & `SDMCFG_TIM_WR_MASK;
    end
  end

  // ****************************************
  // Field decode
  // ****************************************
  assign self_refresh_enable     = memory_control_reg[`SDMCFG_CTL_SELF_REFRESH_BIT];
  assign column_latency_select   = memory_control_reg[`SDMCFG_CTL_CAS_HI:`SDMCFG_CTL_CAS_LO];
  assign self_refresh_exit_delay = refresh_timing_reg[2:0];
  assign row_width_select        = memory_bank_geometry_reg[`SDMCFG_BANK_ROW_HI:`SDMCFG_BANK_ROW_LO];
  assign bank_count_select       = memory_bank_geometry_reg[`SDMCFG_BANK_BANKS_HI:`SDMCFG_BANK_BANKS_LO];
  assign column_width_select     = memory_bank_geometry_reg[`SDMCFG_BANK_COL_HI:`SDMCFG_BANK_COL_LO];
  assign sdram_size_code         = memory_bank_geometry_reg[`SDMCFG_BANK_SIZE_HI:`SDMCFG_BANK_SIZE_LO];
  assign data_width_type         = memory_bank_geometry_reg[`SDMCFG_BANK_WIDTH_BIT];
  assign cs1_masked              = memory_bank_geometry_reg[`SDMCFG_BANK_CS1_MASK_BIT];

  assign cas_latency   = cas_clocks(column_latency_select);
  // row width, reserved codes read as eleven
  assign row_addr_bits = (row_width_select == 3'h1) ? 4'hC : (row_width_select == 3'h2) ? 4'hD : 4'hB;
  assign bank_count    = (4'h1 << bank_count_select);
  // column width, 1xx read as eight
  assign col_addr_bits = column_width_select[2] ? 4'h8 : (4'h8 + {2'h0, column_width_select[1:0]});
  assign geometry_reserved = (row_width_select > 3'h2) | column_width_select[2];

  // ****************************************
  // Command sequencer
  // ****************************************
  // load only with banks idle
  assign mode_issue  = (state_reg == ST_IDLE) && banks_idle && memory_control_reg[`SDMCFG_CTL_MODE_TRIG_BIT];
  assign ctrl_ready  = (state_reg == ST_IDLE) && !mode_issue && !(self_refresh_enable && banks_idle);
  // code gives clocks, zero held to one
  assign exit_clocks = (self_refresh_exit_delay == 3'h0) ? 3'h1 : self_refresh_exit_delay;

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (mode_issue)
          state_next = ST_MODE;
        else if (self_refresh_enable && banks_idle)
          state_next = ST_SREF;
      end
      ST_MODE: state_next = ST_IDLE;
      ST_SREF:
      begin
        if (!self_refresh_enable)
          state_next = ST_SREX;
      end
      ST_SREX:
      begin
        if (exit_count_reg <= 3'h1)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg      <= ST_IDLE;
      exit_count_reg <= 3'h0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == ST_SREF)
        exit_count_reg <= exit_clocks;
      else if (exit_count_reg != 3'h0)
        exit_count_reg <= exit_count_reg - 3'h1;
    end
  end

  // Registered pins, one command cycle per transition
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sdram_cke   <= 1'b1;
      sdram_cs_n  <= 2'h3;
      sdram_ras_n <= 1'b1;
      sdram_cas_n <= 1'b1;
      sdram_we_n  <= 1'b1;
      sdram_addr  <= 13'h0000;
    end
    else
    begin
      sdram_cs_n                                 <= 2'h3;
      {sdram_ras_n, sdram_cas_n, sdram_we_n}     <= `SDMCFG_CMD_NOP;
      sdram_addr                                 <= 13'h0000;
      if (state_reg == ST_IDLE && state_next == ST_MODE)
      begin
        sdram_cs_n                             <= {cs1_masked, 1'b0};
        {sdram_ras_n, sdram_cas_n, sdram_we_n} <= `SDMCFG_CMD_MODE_LOAD;
        // latency in A6-A4, burst of one
        sdram_addr                             <= {6'h00, cas_latency, 4'h0};
      end
      else if (state_reg == ST_IDLE && state_next == ST_SREF)
      begin
        sdram_cs_n                             <= {cs1_masked, 1'b0};
        {sdram_ras_n, sdram_cas_n, sdram_we_n} <= `SDMCFG_CMD_SELF_REFRESH;
        sdram_cke                              <= 1'b0;
      end
      else if (state_reg == ST_SREF && state_next == ST_SREX)
        sdram_cke <= 1'b1;
    end
  end

endmodule

// File: verification/sdmcfg_chk.sv
// Concurrent checks on the SDRAM configuration block ports
`timescale 1ns/1ps
`include "sdmcfg_consts.vh"
module sdmcfg_chk
(
  input wire logic        pclk,          // Clock
  input wire logic        presetn,       // Reset
  input wire logic        psel,          // Select
  input wire logic        penable,       // Access
  input wire logic        pwrite,        // Write
  input wire logic [11:0] paddr,         // Address
  input wire logic [31:0] pwdata,        // Data
  input wire logic        banks_idle,    // Idle
  input wire logic        sdram_cke,     // Clock enable
  input wire logic [1:0]  sdram_cs_n,    // Selects
  input wire logic        sdram_ras_n,   // Row strobe
  input wire logic        sdram_cas_n,   // Col strobe
  input wire logic        sdram_we_n,    // Write enable
  input wire logic [12:0] sdram_addr,    // Address
  input wire logic [2:0]  cas_latency,   // Latency
  input wire logic [3:0]  row_addr_bits, // Rows
  input wire logic [3:0]  col_addr_bits, // Columns
  input wire logic [3:0]  bank_count,    // Banks
  input wire logic        cs1_masked     // Mask
);
  // ****
  // Decoded events
  // ****
  wire       acc = psel & penable & pwrite;
  wire       wr_ctl = acc & (paddr == `SDMCFG_ADDR_MEMORY_CONTROL);
  wire       wr_geo = acc & (paddr == `SDMCFG_ADDR_BANK_GEOMETRY);
  wire [2:0] cmd = {sdram_ras_n, sdram_cas_n, sdram_we_n};
  wire       load = !sdram_cs_n[0] && cmd == `SDMCFG_CMD_MODE_LOAD;
  wire       srf = !sdram_cs_n[0] && cmd == `SDMCFG_CMD_SELF_REFRESH;
  wire [2:0] row_code = pwdata[7:5];
  wire [1:0] bank_code = pwdata[4:3];
  wire [1:0] col_lo = pwdata[1:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_load_word: assert property (load |-> sdram_addr == {6'h00, $past(cas_latency), 4'h0})
    else $error("mode word does not carry latency");
  a_load_idle: assert property (load |-> $past(banks_idle))
    else $error("mode load while banks busy");
  a_cs1_mask: assert property (cs1_masked |-> sdram_cs_n[1])
    else $error("masked chip select asserted");
  a_cs1_open: assert property (srf && !$past(cs1_masked) |-> !sdram_cs_n[1])
    else $error("unmasked chip select not asserted");
  a_srf_cke: assert property (srf |-> !sdram_cke)
    else $error("clock enable high on self-refresh entry");
  a_cas_two: assert property (wr_ctl && pwdata[2:1] == 2'h2 |=> cas_latency == 3'h2)
    else $error("latency not two");
  a_cas_three: assert property (wr_ctl && pwdata[2:1] == 2'h3 |=> cas_latency == 3'h3)
    else $error("latency not three");
  a_bank_count: assert property (wr_geo |=> bank_count == 4'h1 << $past(bank_code))
    else $error("bank count wrong");
  a_row_bits: assert property (wr_geo && pwdata[7:6] == 2'h0 |=> row_addr_bits == 4'hB + $past(row_code))
    else $error("row width wrong");
  a_col_bits: assert property (wr_geo && !pwdata[2] |=> col_addr_bits == 4'h8 + $past(col_lo))
    else $error("column width wrong");
  c_load: cover property (load);
  c_srf: cover property (srf);
  c_geo: cover property (wr_geo);
endmodule
bind sdmcfg_top sdmcfg_chk u_sdmcfg_chk (.*);

// File: verification/sdmcfg_sdram_model.sv
// Behavioural SDRAM device that reports bank state and records commands
`timescale 1ns/1ps
module sdmcfg_sdram_model
(
  input  wire logic        pclk,       // Clock
  input  wire logic        presetn,    // Reset, active low
  input  wire logic        hold_busy,  // Bench stalls the banks
  input  wire logic [1:0]  cs_n,       // Chip selects
  input  wire logic [2:0]  cmd,        // Row, column, write strobes
  input  wire logic [12:0] addr,       // Address
  output logic             banks_idle, // All banks precharged
  output logic [12:0]      mode_word,  // Last mode word
  output int               load_cnt,   // Mode loads seen
  output int               srf_cnt     // Self-refresh entries
);
  assign banks_idle = ~hold_busy;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      load_cnt <= 0;
      srf_cnt <= 0;
      mode_word <= 13'h0000;
    end
    else if (!cs_n[0] && cmd == 3'h0)
    begin
      load_cnt <= load_cnt + 1;
      mode_word <= addr;
    end
    else if (!cs_n[0] && cmd == 3'h1)
      srf_cnt <= srf_cnt + 1;
endmodule

// File: verification/sdmcfg_top_tb.sv
// Self-checking testbench for the SDRAM configuration block
`timescale 1ns/1ps
`include "sdmcfg_consts.vh"
module sdmcfg_top_tb;
  localparam logic [11:0] ctl_a = `SDMCFG_ADDR_MEMORY_CONTROL;
  localparam logic [11:0] geo_a = `SDMCFG_ADDR_BANK_GEOMETRY;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hold_busy = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, v;
  wire  [31:0] prdata;
  wire         pready, pslverr, banks_idle, cke, ras_n, cas_n, we_n, ctrl_ready, cs1_masked, width_type, geo_rsvd;
  wire  [1:0]  cs_n;
  wire  [12:0] addr, mode_word;
  wire  [2:0]  cas_latency;
  wire  [3:0]  row_addr_bits, col_addr_bits, bank_count, size_code;
  int          mismatches = 0, num_checks = 0, cycles = 0, load_cnt, srf_cnt, n, d[2];
  sdmcfg_top u_sdmcfg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .banks_idle(banks_idle), .sdram_cke(cke), .sdram_cs_n(cs_n), .sdram_ras_n(ras_n), .sdram_cas_n(cas_n),
    .sdram_we_n(we_n), .sdram_addr(addr), .ctrl_ready(ctrl_ready), .cas_latency(cas_latency),
    .row_addr_bits(row_addr_bits), .col_addr_bits(col_addr_bits), .bank_count(bank_count),
    .sdram_size_code(size_code), .data_width_type(width_type), .cs1_masked(cs1_masked),
    .geometry_reserved(geo_rsvd));
  sdmcfg_sdram_model u_sdmcfg_sdram_model (.pclk(pclk), .presetn(presetn), .hold_busy(hold_busy),
    .cs_n(cs_n), .cmd({ras_n, cas_n, we_n}), .addr(addr), .banks_idle(banks_idle),
    .mode_word(mode_word), .load_cnt(load_cnt), .srf_cnt(srf_cnt));
  always #25 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      complete_run;
    end
  end
  // ****
  // Bus and compare tasks
  // ****
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // ****
  // Scenarios
  // ****
  task t_reset;
    apb(0, ctl_a, 0); check("control reset", 32'h00000004, rd);
    apb(0, geo_a, 0); check("geometry reset", 32'h00000331, rd);
    apb(0, 12'h1FC, 0); check("unmapped error", 32'h00000001, {31'h0, err});
    check("unmapped read", 32'h00000000, rd);
    $display("test reset done");
  endtask
  task t_cas;
    for (int i = 0; i < 4; i++)
    begin
      apb(1, ctl_a, i << 1); check("latency", (i == 2) ? 32'h2 : 32'h3, {29'h0, cas_latency});
      apb(0, ctl_a, 0); check("control readback", i << 1, rd);
    end
    $display("test latency done");
  endtask
  task t_geo;
    for (int k = 0; k < 4; k++)
    begin
      v = (k[0] << 13) | (k[1] << 12) | (k << 8) | ((k % 3) << 5) | (k << 3) | k;
      apb(1, geo_a, v);
      apb(0, geo_a, 0); check("geometry readback", v, rd);
      check("rows", 11 + k % 3, {28'h0, row_addr_bits});
      check("banks", 1 << k, {28'h0, bank_count});
      check("columns", 8 + k, {28'h0, col_addr_bits});
      check("cs1 mask", k[0], {31'h0, cs1_masked});
      check("size code", k, {28'h0, size_code});
      check("width type", k[1], {31'h0, width_type});
      check("geometry reserved", 0, {31'h0, geo_rsvd});
    end
    apb(1, geo_a, 32'h00003A64);
    check("reserved rows", 11, {28'h0, row_addr_bits});
    check("reserved columns", 8, {28'h0, col_addr_bits});
    check("reserved flag", 1, {31'h0, geo_rsvd});
    check("reserved size code", 32'hA, {28'h0, size_code});
    $display("test geometry done");
  endtask
  task t_load;
    for (int i = 0; i < 2; i++)
    begin
      hold_busy <= 1;
      apb(1, ctl_a, 32'h8 | ((3 - i) << 1));
      repeat (5) @(posedge pclk);
      check("load held while busy", i, load_cnt);
      hold_busy <= 0;
      repeat (20) if (load_cnt == i) @(posedge pclk);
      check("load issued", i + 1, load_cnt);
      check("mode word", (3 - i) << 4, {19'h0, mode_word});
      apb(0, ctl_a, 0); check("trigger cleared", (3 - i) << 1, rd);
    end
    $display("test mode load done");
  endtask
  task t_srf;
    apb(1, geo_a, 32'h00000331);
    for (int i = 0; i < 2; i++)
    begin
      apb(1, 12'h1A0, i ? 5 : 3);
      apb(1, ctl_a, 32'h5);
      repeat (50) if (cke !== 1'b0) @(posedge pclk);
      check("self-refresh entry", 32'h0, {31'h0, cke});
      apb(1, ctl_a, 32'h4);
      repeat (50) if (cke !== 1'b1) @(posedge pclk);
      check("self-refresh exit", 32'h1, {31'h0, cke});
      for (n = 0; n < 50 && ctrl_ready !== 1'b1; n++) @(posedge pclk);
      d[i] = n;
      check("exit delay", i ? 5 : 3, d[i]);
    end
    check("entries", 2, srf_cnt);
    check("exit delay step", 2, d[1] - d[0]);
    $display("test self-refresh done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset;
    t_cas;
    t_geo;
    t_load;
    t_srf;
    complete_run;
  end
endmodule
